// ===== design/hmp_pkg.sv
package hmp_pkg;

  // Width of every byte register on both sides
  localparam int          BYTE_W      = 8;
  // Number of host channels
  localparam int          CHAN_N      = 2;

  // Slave-side register selects, channel index added to the base
  localparam logic [2:0]  SEL_IN_ONE  = 3'h0;  // Host input byte, channel one
  localparam logic [2:0]  SEL_OUT_ONE = 3'h2;  // Host output byte, channel one
  localparam logic [2:0]  SEL_FLG_ONE = 3'h4;  // Flag register, channel one
  localparam logic [2:0]  SEL_W       = 3'h0;  // Unused marker for width only

  // Flag register field positions
  localparam int          OBF_BIT     = 0;     // Output-full flag
  localparam int          IBF_BIT     = 1;     // Input-full flag
  localparam int          CMD_BIT     = 3;     // Command or data marker

  // Bits that slave software may write freely
  localparam logic [7:0]  USER_MASK   = 8'hF4;
  // Flag register value after reset and in standby
  localparam logic [7:0]  FLAGS_RST   = 8'h00;
  // Byte register value after reset
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  // Layout of the host pin sample vector
  localparam int          P_CS1       = 0;     // Chip select one, low active
  localparam int          P_CS2       = 1;     // Chip select two, low active
  localparam int          P_RD        = 2;     // Read strobe, low active
  localparam int          P_WR        = 3;     // Write strobe, low active
  localparam int          P_ADDR      = 4;     // Address select bit
  localparam int          P_DATA      = 5;     // Lowest data bit
  localparam int          PIN_W       = 13;    // Total sampled pin width

  // Reset value of the pin samplers: strobes and selects idle high
  localparam logic [12:0] PIN_RST     = 13'h000F;

endpackage : hmp_pkg

// ===== design/hmp_port.sv
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Slave reads and writes channel-two output byte
// - Drive output byte two on host read
// - Flags two cleared by reset, standby
// - Command, input-full, output-full bits stay read-only
// - Bits 7-4 and 2 are user bits
// - Command bit captures address on host write
// - Host write sets input-full flag
// - Slave read of input byte clears it
// - Input-full flag is slave interrupt source
// - Slave write of output byte sets output-full
// - Host read of output byte clears output-full
// - Port active only when enable bit set
// - Slave mode takes over host pins
// - Channel one read: data or flags
// - Channel one write: data or command
// - Channel two read: data or flags
// - Channel two write: data or command
// - Host write latches byte into input two
// - Host write latches byte into input one
// - Channel one flags follow same edges
// - Channel-two interrupt gated by its enable
module hmp_port
  import hmp_pkg::*;
(
  input  wire logic                      REF_CLK_IN,             // Chip clock
  input  wire logic                      RESET_IN,               // Sync reset, high
  input  wire logic                      STANDBY_IN,             // Standby mode level
  input  wire logic                      HOST_PORT_ENABLE_IN,    // Slave mode enable
  input  wire logic                      IRQ_ENABLE_ONE_IN,      // Input-full irq enable 1
  input  wire logic                      IRQ_ENABLE_TWO_IN,      // Input-full irq enable 2
  input  wire logic                      HOST_CS_ONE_N_IN,       // Host chip select one
  input  wire logic                      HOST_CS_TWO_N_IN,       // Host chip select two
  input  wire logic                      HOST_RD_N_IN,           // Host read strobe
  input  wire logic                      HOST_WR_N_IN,           // Host write strobe
  input  wire logic                      HOST_ADDR_IN,           // Host address select
  input  wire logic [hmp_pkg::BYTE_W-1:0] HOST_DATA_IN,          // Host data bus in
  output logic      [hmp_pkg::BYTE_W-1:0] HOST_DATA_OUT,         // Host data bus out
  output logic                           HOST_DATA_OE_N_OUT,     // Low while driving
  output logic                           HOST_PINS_TAKEN_OUT,    // Pins owned by port
  input  wire logic [2:0]                SLV_SEL_IN,             // Slave register select
  input  wire logic                      SLV_RD_N_IN,            // Slave read strobe
  input  wire logic                      SLV_WR_N_IN,            // Slave write strobe
  input  wire logic [hmp_pkg::BYTE_W-1:0] SLV_WDATA_IN,          // Slave write data
  output logic      [hmp_pkg::BYTE_W-1:0] SLV_RDATA_OUT,         // Slave read data
  output logic                           IRQ_IN_FULL_ONE_OUT,    // Input-full irq 1
  output logic                           IRQ_IN_FULL_TWO_OUT     // Input-full irq 2
);

  // Channel chosen alone by its chip select, both low means none
  function automatic logic chan_hit(input logic cs1_n, input logic cs2_n, input int ch);
    chan_hit = (ch == 0) ? (!cs1_n && cs2_n) : (cs1_n && !cs2_n);
  endfunction : chan_hit

  // Slave select code of a register kind for one channel
  function automatic logic [2:0] sel_code(input logic [2:0] base, input int ch);
    sel_code = base + 3'(ch);
  endfunction : sel_code

  // Host pin sampler stages; stage one feeds only stage two
  logic [PIN_W-1:0]  pin_s1_r;      // First synchroniser stage
  logic [PIN_W-1:0]  pin_s2_r;      // Second synchroniser stage
  logic [PIN_W-1:0]  pin_s3_r;      // Delayed copy for edge detection
  logic [PIN_W-1:0]  pin_now;       // Raw pin vector
  logic [2:0]        en_pipe_r;     // Port enable, aligned with stage three

  // Slave strobe delay flops for edge detection
  logic              slv_rd_n_d_r;  // Slave read strobe, one cycle old
  logic              slv_wr_n_d_r;  // Slave write strobe, one cycle old

  // Per-channel register storage
  logic [BYTE_W-1:0] in_byte_r  [CHAN_N];  // Host input bytes
  logic [BYTE_W-1:0] in_byte_nxt [CHAN_N];
  logic [BYTE_W-1:0] out_byte_r [CHAN_N];  // Host output bytes
  logic [BYTE_W-1:0] out_byte_nxt [CHAN_N];
  logic [BYTE_W-1:0] flags_r    [CHAN_N];  // Flag registers
  logic [BYTE_W-1:0] flags_nxt  [CHAN_N];
  logic [CHAN_N-1:0] irq_r;                // Gated interrupt requests
  logic [CHAN_N-1:0] irq_nxt;

  // Output data flops
  logic [BYTE_W-1:0] host_dout_r;   // Byte presented to host
  logic [BYTE_W-1:0] host_dout_nxt;
  logic [BYTE_W-1:0] slv_rdata_r;   // Byte returned to slave
  logic [BYTE_W-1:0] slv_rdata_nxt;

  // Decoded events
  logic              wr_rise;       // Host write strobe released
  logic              rd_rise;       // Host read strobe released
  logic              slv_rd_fall;   // Slave read strobe asserted
  logic              slv_wr_fall;   // Slave write strobe asserted
  logic [CHAN_N-1:0] host_wr_ev;    // Host write finished per channel
  logic [CHAN_N-1:0] host_rd_ev;    // Host output-byte read finished
  logic [CHAN_N-1:0] slv_in_rd;     // Slave read of an input byte
  logic [CHAN_N-1:0] slv_out_wr;    // Slave write of an output byte
  logic [CHAN_N-1:0] slv_flg_wr;    // Slave write of a flag register
  logic              host_read_now; // Valid host read on the raw pins
  logic              read_chan;     // Channel addressed by raw pins

  // Gather the raw host pins into one vector
  assign pin_now = {HOST_DATA_IN, HOST_ADDR_IN, HOST_WR_N_IN, HOST_RD_N_IN,
                    HOST_CS_TWO_N_IN, HOST_CS_ONE_N_IN};

  // Sample the host pins through two stages, then delay once more
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      pin_s1_r <= PIN_RST;
      pin_s2_r <= PIN_RST;
      pin_s3_r <= PIN_RST;
      en_pipe_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_now;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      en_pipe_r <= {en_pipe_r[1:0], HOST_PORT_ENABLE_IN};
    end
  end

  // Edges of the synchronised strobes; stage three holds pre-edge pins
  assign wr_rise = pin_s2_r[P_WR] && !pin_s3_r[P_WR];
  assign rd_rise = pin_s2_r[P_RD] && !pin_s3_r[P_RD];

  // Slave strobe edges
  assign slv_rd_fall = slv_rd_n_d_r && !SLV_RD_N_IN;
  assign slv_wr_fall = slv_wr_n_d_r && !SLV_WR_N_IN;

  // Decode host and slave events for each channel
  always_comb
  begin
    for (int ch = 0; ch < CHAN_N; ch++)
    begin
      // Host write with read strobe idle on a singly selected channel
      // Enable must stand both when the pins were sampled and at the edge
      host_wr_ev[ch] = HOST_PORT_ENABLE_IN && en_pipe_r[2] && wr_rise && pin_s3_r[P_RD] &&
                       chan_hit(pin_s3_r[P_CS1], pin_s3_r[P_CS2], ch);
      // Host read of the output byte: address low, write idle
      host_rd_ev[ch] = HOST_PORT_ENABLE_IN && en_pipe_r[2] && rd_rise && pin_s3_r[P_WR] &&
                       !pin_s3_r[P_ADDR] &&
                       chan_hit(pin_s3_r[P_CS1], pin_s3_r[P_CS2], ch);
      slv_in_rd[ch]  = slv_rd_fall && (SLV_SEL_IN == sel_code(SEL_IN_ONE, ch));
      slv_out_wr[ch] = slv_wr_fall && (SLV_SEL_IN == sel_code(SEL_OUT_ONE, ch));
      slv_flg_wr[ch] = slv_wr_fall && (SLV_SEL_IN == sel_code(SEL_FLG_ONE, ch));
    end
  end

  // Next values of the channel registers and interrupts
  always_comb
  begin
    for (int ch = 0; ch < CHAN_N; ch++)
    begin
      in_byte_nxt[ch]  = in_byte_r[ch];
      out_byte_nxt[ch] = out_byte_r[ch];
      flags_nxt[ch]    = flags_r[ch];
      // Host write latches data and the command marker
      if (host_wr_ev[ch])
      begin
        in_byte_nxt[ch]        = pin_s3_r[P_DATA +: BYTE_W];
        flags_nxt[ch][CMD_BIT] = pin_s3_r[P_ADDR];
      end
      // Slave write of the output byte
      if (slv_out_wr[ch])
        out_byte_nxt[ch] = SLV_WDATA_IN;
      // Slave write touches only the user bits
      if (slv_flg_wr[ch])
        flags_nxt[ch] = (flags_nxt[ch] & ~USER_MASK) |
                        (SLV_WDATA_IN & USER_MASK);
      // Input-full: slave read clears, host write sets, set wins
      if (slv_in_rd[ch])
        flags_nxt[ch][IBF_BIT] = 1'b0;
      if (host_wr_ev[ch])
        flags_nxt[ch][IBF_BIT] = 1'b1;
      // Output-full: host read clears, slave write sets, set wins
      if (host_rd_ev[ch])
        flags_nxt[ch][OBF_BIT] = 1'b0;
      if (slv_out_wr[ch])
        flags_nxt[ch][OBF_BIT] = 1'b1;
      // Standby holds the flags at their reset value
      if (STANDBY_IN)
        flags_nxt[ch] = FLAGS_RST;
    end
    // Input-full raises a slave interrupt when enabled
    irq_nxt[0] = flags_nxt[0][IBF_BIT] && IRQ_ENABLE_ONE_IN;
    irq_nxt[1] = flags_nxt[1][IBF_BIT] && IRQ_ENABLE_TWO_IN;
  end

  // Register the channel state
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      for (int ch = 0; ch < CHAN_N; ch++)
      begin
        in_byte_r[ch]  <= BYTE_RST;
        out_byte_r[ch] <= BYTE_RST;
        flags_r[ch]    <= FLAGS_RST;
      end
      irq_r        <= '0;
      slv_rd_n_d_r <= 1'b1;
      slv_wr_n_d_r <= 1'b1;
    end
    else
    begin
      in_byte_r    <= in_byte_nxt;
      out_byte_r   <= out_byte_nxt;
      flags_r      <= flags_nxt;
      irq_r        <= irq_nxt;
      slv_rd_n_d_r <= SLV_RD_N_IN;
      slv_wr_n_d_r <= SLV_WR_N_IN;
    end
  end

  // Host read decode from the raw pins; one channel, read alone
  assign host_read_now = HOST_PORT_ENABLE_IN && !HOST_RD_N_IN && HOST_WR_N_IN &&
                         (HOST_CS_ONE_N_IN != HOST_CS_TWO_N_IN);
  assign read_chan     = !HOST_CS_TWO_N_IN;

  // Choose the byte for the host and for the slave
  always_comb
  begin
    host_dout_nxt = host_dout_r;
    if (host_read_now)
    begin
      // Address high returns flags, low returns the output byte
      if (HOST_ADDR_IN)
        host_dout_nxt = flags_r[read_chan];
      else
        host_dout_nxt = out_byte_r[read_chan];
    end
    slv_rdata_nxt = slv_rdata_r;
    if (slv_rd_fall)
    begin
      case (SLV_SEL_IN)
        sel_code(SEL_IN_ONE, 0):  slv_rdata_nxt = in_byte_r[0];
        sel_code(SEL_IN_ONE, 1):  slv_rdata_nxt = in_byte_r[1];
        sel_code(SEL_OUT_ONE, 0): slv_rdata_nxt = out_byte_r[0];
        sel_code(SEL_OUT_ONE, 1): slv_rdata_nxt = out_byte_r[1];
        sel_code(SEL_FLG_ONE, 0): slv_rdata_nxt = flags_r[0];
        sel_code(SEL_FLG_ONE, 1): slv_rdata_nxt = flags_r[1];
        default:                  slv_rdata_nxt = BYTE_RST;       // Unmapped select
      endcase
    end
  end

  // Register the data outputs
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RESET_IN)
    begin
      host_dout_r <= BYTE_RST;
      slv_rdata_r <= BYTE_RST;
    end
    else
    begin
      host_dout_r <= host_dout_nxt;
      slv_rdata_r <= slv_rdata_nxt;
    end
  end

  // Outputs
  assign HOST_DATA_OUT       = host_dout_r;
  assign HOST_DATA_OE_N_OUT  = !(host_read_now && !RESET_IN);
  assign HOST_PINS_TAKEN_OUT = HOST_PORT_ENABLE_IN;
  assign SLV_RDATA_OUT       = slv_rdata_r;
  assign IRQ_IN_FULL_ONE_OUT = irq_r[0];
  assign IRQ_IN_FULL_TWO_OUT = irq_r[1];

  // Slave write of output byte two sets output-full
  obf_set_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (slv_out_wr[1] && !STANDBY_IN) |=> (flags_r[1][OBF_BIT] && out_byte_r[1] == $past(SLV_WDATA_IN)))
    else $error("output-full two not set by slave write");

  // Host write on channel two sets input-full and latches data
  ibf_set_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (host_wr_ev[1] && !STANDBY_IN) |=> (flags_r[1][IBF_BIT] &&
      in_byte_r[1] == $past(pin_s3_r[P_DATA +: BYTE_W])))
    else $error("input-full two not set by host write");

  // Slave read clears input-full when no host write competes
  ibf_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (slv_in_rd[1] && !host_wr_ev[1]) |=> !flags_r[1][IBF_BIT])
    else $error("input-full two not cleared by slave read");

  // Host read of output byte two clears output-full
  obf_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (host_rd_ev[1] && !slv_out_wr[1]) |=> !flags_r[1][OBF_BIT])
    else $error("output-full two not cleared by host read");

  // Command bit follows the latched address bit
  cmd_bit_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (host_wr_ev[1] && !STANDBY_IN) |=> (flags_r[1][CMD_BIT] == $past(pin_s3_r[P_ADDR])))
    else $error("command bit two does not match address");

  // Standby leaves the flags at zero
  standby_clear_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    STANDBY_IN |=> (flags_r[1] == FLAGS_RST && !IRQ_IN_FULL_TWO_OUT))
    else $error("flags two not cleared in standby");

  // Slave flag writes leave the hardware bits alone
  ro_bits_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (slv_flg_wr[1] && !host_wr_ev[1] && !host_rd_ev[1] && !STANDBY_IN) |=>
      ((flags_r[1] & ~USER_MASK) == $past(flags_r[1] & ~USER_MASK)))
    else $error("slave write changed a read-only flag");

  // Slave flag writes store the user bits
  user_bits_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (slv_flg_wr[1] && !STANDBY_IN) |=> ((flags_r[1] & USER_MASK) == $past(SLV_WDATA_IN & USER_MASK)))
    else $error("user bits two not stored");

  // Host data read on channel two returns output byte two
  drive_out_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (!HOST_DATA_OE_N_OUT && !HOST_CS_TWO_N_IN && !HOST_ADDR_IN) |=>
      (HOST_DATA_OUT == $past(out_byte_r[1])))
    else $error("host read two returned wrong byte");

  // Interrupt two follows input-full and its enable
  irq_gate_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    ##1 (IRQ_IN_FULL_TWO_OUT == (flags_r[1][IBF_BIT] && $past(IRQ_ENABLE_TWO_IN))))
    else $error("interrupt two does not track input-full");

  // Disabled port or double select never drives the bus
  no_drive_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (!HOST_PORT_ENABLE_IN || (!HOST_CS_ONE_N_IN && !HOST_CS_TWO_N_IN)) |-> HOST_DATA_OE_N_OUT)
    else $error("host bus driven without valid access");

  // Interrupt one follows input-full one and its enable
  irq_one_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    ##1 (IRQ_IN_FULL_ONE_OUT == (flags_r[0][IBF_BIT] && $past(IRQ_ENABLE_ONE_IN))))
    else $error("interrupt one does not track input-full");

  // Host write on channel one sets input-full one
  ibf_one_a: assert property (@(posedge REF_CLK_IN) disable iff (RESET_IN)
    (host_wr_ev[0] && !STANDBY_IN) |=> flags_r[0][IBF_BIT])
    else $error("input-full one not set by host write");

endmodule : hmp_port

`default_nettype wire

// ===== dv/hmp_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host processor model; channel code 1 = one, 2 = two, 3 = both
module hmp_host_model
(
  input  wire logic       clk_in,        // Chip clock for pacing
  input  wire logic [7:0] rdata_in,      // Device data toward host
  input  wire logic       oe_n_in,       // Device drive enable
  output logic            cs_one_n_out,  // Chip select one
  output logic            cs_two_n_out,  // Chip select two
  output logic            rd_n_out,      // Read strobe
  output logic            wr_n_out,      // Write strobe
  output logic            addr_out,      // Address select
  output logic [7:0]      data_out       // Host data bus
);
  // Idle bus at time zero
  initial
  begin
    cs_one_n_out = 1'b1;
    cs_two_n_out = 1'b1;
    rd_n_out     = 1'b1;
    wr_n_out     = 1'b1;
    addr_out     = 1'b0;
    data_out     = 8'h00;
  end

  // Write; data set three clocks before the falling strobe, held one clock past the rising strobe
  task automatic hwrite(input logic [1:0] ch, input logic a, input logic [7:0] d);
    @(negedge clk_in);
    cs_one_n_out = ~ch[0];
    cs_two_n_out = ~ch[1];
    addr_out     = a;
    data_out     = d;
    repeat (3) @(negedge clk_in);
    wr_n_out = 1'b0;
    repeat (3) @(negedge clk_in);
    wr_n_out = 1'b1;
    @(negedge clk_in);
    cs_one_n_out = 1'b1;
    cs_two_n_out = 1'b1;
    data_out     = ~d;  // Released bus shows no stale byte
  endtask : hwrite

  // Read; strobe held low three clocks, byte taken before release
  task automatic hread(input logic [1:0] ch, input logic a, output logic [7:0] d,
                       output logic oe);
    @(negedge clk_in);
    cs_one_n_out = ~ch[0];
    cs_two_n_out = ~ch[1];
    addr_out     = a;
    rd_n_out     = 1'b0;
    repeat (2) @(negedge clk_in);
    d  = oe_n_in ? ~rdata_in : rdata_in;  // Undriven bus shows no stale byte
    oe = oe_n_in;
    @(negedge clk_in);
    rd_n_out = 1'b1;
    @(negedge clk_in);
    cs_one_n_out = 1'b1;
    cs_two_n_out = 1'b1;
    @(negedge clk_in);  // Strobe idle three clocks before the next access
  endtask : hread
endmodule : hmp_host_model

`default_nettype wire

// ===== dv/hmp_port_bench.sv
`timescale 1ns/1ps
`default_nettype none

module hmp_port_bench;
  import hmp_pkg::*;
  logic       clk = 1'b0;    // Chip clock
  logic       rst, stby, en;  // Reset, standby, port enable
  logic       ie1, ie2;       // Irq enables
  logic       cs1_n, cs2_n, rd_n, wr_n, addr;  // Host pins
  logic [7:0] hdi, hdo, swd, srd;  // Data buses
  logic       oe_n, taken, irq1, irq2;  // Device flags
  logic [2:0] sel;            // Slave select
  logic       srd_n, swr_n;   // Slave strobes
  int         miscompares = 0;
  int         tests_run = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  hmp_port u_dut (.REF_CLK_IN(clk), .RESET_IN(rst), .STANDBY_IN(stby),
    .HOST_PORT_ENABLE_IN(en), .IRQ_ENABLE_ONE_IN(ie1), .IRQ_ENABLE_TWO_IN(ie2),
    .HOST_CS_ONE_N_IN(cs1_n), .HOST_CS_TWO_N_IN(cs2_n), .HOST_RD_N_IN(rd_n),
    .HOST_WR_N_IN(wr_n), .HOST_ADDR_IN(addr), .HOST_DATA_IN(hdi),
    .HOST_DATA_OUT(hdo), .HOST_DATA_OE_N_OUT(oe_n), .HOST_PINS_TAKEN_OUT(taken),
    .SLV_SEL_IN(sel), .SLV_RD_N_IN(srd_n), .SLV_WR_N_IN(swr_n), .SLV_WDATA_IN(swd),
    .SLV_RDATA_OUT(srd), .IRQ_IN_FULL_ONE_OUT(irq1), .IRQ_IN_FULL_TWO_OUT(irq2));

  hmp_host_model u_host (.clk_in(clk), .rdata_in(hdo), .oe_n_in(oe_n),
    .cs_one_n_out(cs1_n), .cs_two_n_out(cs2_n), .rd_n_out(rd_n),
    .wr_n_out(wr_n), .addr_out(addr), .data_out(hdi));

  // Compare and count
  task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
    tests_run++;
    if (got !== ex)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  // Slave write: one clock low on the strobe
  task automatic slv_wr(input logic [2:0] s, input logic [7:0] d);
    @(negedge clk);
    sel   = s;
    swd   = d;
    swr_n = 1'b0;
    @(negedge clk);
    swr_n = 1'b1;
    @(negedge clk);
  endtask : slv_wr

  // Slave read and compare
  task automatic rdchk(input string nm, input logic [2:0] s, input logic [7:0] ex);
    @(negedge clk);
    sel   = s;
    srd_n = 1'b0;
    @(negedge clk);
    srd_n = 1'b1;
    @(negedge clk);
    chk(nm, ex, srd);
  endtask : rdchk

  // Host read; byte compared only when the device should drive
  task automatic hchk(input string nm, input logic [1:0] ch, input logic a,
                      input logic [7:0] ex, input logic exoe);
    logic [7:0] v;
    logic       o;
    u_host.hread(ch, a, v, o);
    chk({nm, " enable"}, {7'h00, exoe}, {7'h00, o});
    if (!exoe)
      chk(nm, ex, v);
  endtask : hchk

  task automatic t_reset;
    rdchk("flags two", 3'h5, 8'h00);
    rdchk("flags one", 3'h4, 8'h00);
    rdchk("unmapped", 3'h6, 8'h00);
    chk("pins taken", 8'h01, {7'h00, taken});
    $display("done: reset values");
  endtask : t_reset

  task automatic t_out_two;
    slv_wr(3'h3, 8'hA5);
    rdchk("flags two", 3'h5, 8'h01);
    rdchk("out byte two", 3'h3, 8'hA5);
    hchk("host flags two", 2'h2, 1'b1, 8'h01, 1'b0);
    hchk("host out two", 2'h2, 1'b0, 8'hA5, 1'b0);
    idle(5);
    rdchk("flags two", 3'h5, 8'h00);
    $display("done: output byte two");
  endtask : t_out_two

  task automatic t_in_two;
    ie2 = 1'b1;
    u_host.hwrite(2'h2, 1'b1, 8'h3C);
    idle(5);
    chk("irq two", 8'h01, {7'h00, irq2});
    rdchk("flags two", 3'h5, 8'h0A);
    rdchk("in byte two", 3'h1, 8'h3C);
    rdchk("flags two", 3'h5, 8'h08);
    chk("irq two", 8'h00, {7'h00, irq2});
    ie2 = 1'b0;
    u_host.hwrite(2'h2, 1'b0, 8'hC3);
    idle(5);
    rdchk("flags two", 3'h5, 8'h02);
    chk("irq two", 8'h00, {7'h00, irq2});
    $display("done: input byte two");
  endtask : t_in_two

  task automatic t_bits;
    slv_wr(3'h5, 8'hFF);
    rdchk("flags two", 3'h5, 8'hF6);
    hchk("host flags two", 2'h2, 1'b1, 8'hF6, 1'b0);
    slv_wr(3'h5, 8'h00);
    rdchk("flags two", 3'h5, 8'h02);
    $display("done: flag bits");
  endtask : t_bits

  task automatic t_chan_one;
    u_host.hwrite(2'h1, 1'b0, 8'h5A);
    idle(5);
    rdchk("flags one", 3'h4, 8'h02);
    rdchk("in byte one", 3'h0, 8'h5A);
    slv_wr(3'h2, 8'h77);
    hchk("host out one", 2'h1, 1'b0, 8'h77, 1'b0);
    ie1 = 1'b1;
    u_host.hwrite(2'h1, 1'b1, 8'hE1);
    idle(5);
    chk("irq one", 8'h01, {7'h00, irq1});
    rdchk("flags one", 3'h4, 8'h0A);
    $display("done: channel one");
  endtask : t_chan_one

  task automatic t_refuse;
    hchk("both selects", 2'h3, 1'b0, 8'h00, 1'b1);
    en = 1'b0;
    idle(1);
    chk("pins taken", 8'h00, {7'h00, taken});
    u_host.hwrite(2'h2, 1'b1, 8'h11);
    idle(5);
    slv_wr(3'h3, 8'h5A);
    rdchk("flags two", 3'h5, 8'h03);
    hchk("disabled read", 2'h2, 1'b0, 8'h00, 1'b1);
    en = 1'b1;
    idle(5);
    rdchk("flags two", 3'h5, 8'h03);
    $display("done: refused accesses");
  endtask : t_refuse

  task automatic t_standby;
    stby = 1'b1;
    idle(3);
    rdchk("flags in standby", 3'h5, 8'h00);
    chk("irq one", 8'h00, {7'h00, irq1});
    stby = 1'b0;
    rdchk("flags after standby", 3'h5, 8'h00);
    $display("done: standby");
  endtask : t_standby

  // Closing report
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  // Cut a hang short
  initial
  begin
    #200000;
    miscompares++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    {rst, en, stby, ie1, ie2} = 5'b11000;
    {sel, srd_n, swr_n, swd} = {3'h0, 2'b11, 8'h00};
    idle(5);
    rst = 1'b0;
    idle(2);
    t_reset();
    t_out_two();
    t_in_two();
    t_bits();
    t_chan_one();
    t_refuse();
    t_standby();
    give_verdict();
  end
endmodule : hmp_port_bench

`default_nettype wire
